//--- liu_cfg.svh
// Constants for the per-channel line interface register slice
`ifndef LIU_CFG_SVH
`define LIU_CFG_SVH

// ------------------------------------------------------------
// Register indices (byte address = index * 4)
// ------------------------------------------------------------
`define LIU_IDX_RESTEST 6'h03
`define LIU_IDX_IRQEN 6'h04
`define LIU_IDX_LIVE 6'h05
`define LIU_IDX_EVENT 6'h08
`define LIU_IDX_CFG 6'h09

// ------------------------------------------------------------
// Resistor / test control fields
// ------------------------------------------------------------
`define LIU_B_RES_HI 4
`define LIU_B_RES_LO 3
`define LIU_B_INS_BPV 2
`define LIU_B_INS_BER 1
`define LIU_B_RATIO 0
`define LIU_RESTEST_MASK 8'h1F
`define LIU_RES_NONE 2'h0
`define LIU_RES_240 2'h1
`define LIU_RES_210 2'h2
`define LIU_RES_150 2'h3

// ------------------------------------------------------------
// Enable / live status / event layout (bit 7 reserved)
// ------------------------------------------------------------
`define LIU_B_DRV 6
`define LIU_B_FIFO 5
`define LIU_B_LCV 4
`define LIU_B_LOOP 3
`define LIU_B_AIS 2
`define LIU_B_LOS 1
`define LIU_B_PRBS 0
`define LIU_SRC_MASK 8'h7F

// ------------------------------------------------------------
// Channel configuration fields
// ------------------------------------------------------------
`define LIU_B_LCMODE_LO 0
`define LIU_B_LCMODE_HI 1
`define LIU_B_EXT_TERM 2
`define LIU_B_QRSS_EN 3
`define LIU_B_SRAIL 4
`define LIU_CFG_MASK 8'h1F

`define LIU_BYTE_RST 8'h00
`define LIU_WORD_RST 32'h0000_0000

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define LIU_CLK_HZ 10000000
`define LIU_LOOP_QUAL_S 5
`define LIU_LOOP_QUAL_CYC (`LIU_LOOP_QUAL_S * `LIU_CLK_HZ)
`define LIU_LOOP_CNT_W 26
`define LIU_SYNC_W 9

`endif

//--- liu_pkg.sv
// Types shared by the line interface register slice
`default_nettype none
package liu_pkg;

   // Loop-code qualifier states, Gray along hunt -> held
   typedef enum logic [1:0] {
      LIU_LC_OFF = 2'b00,
      LIU_LC_HUNT = 2'b01,
      LIU_LC_HELD = 2'b11,
      LIU_LC_MANUAL = 2'b10
   } liuLcState_t;

   // Loop-code detection mode field
   typedef enum logic [1:0] {
      LIU_LCM_OFF = 2'b00,
      LIU_LCM_MAN_A = 2'b01,
      LIU_LCM_MAN_B = 2'b10,
      LIU_LCM_AUTO = 2'b11
   } liuLcMode_t;

endpackage : liu_pkg
`default_nettype wire

//--- liu_inject_gen.sv
// Test error injection, sampled on the channel transmit clock rising edge
`timescale 1ns/1ps
`default_nettype none
`include "liu_cfg.svh"

module liu_inject_gen (
   input wire logic clk,
   input wire logic resetn,
   input wire logic txClkSync,
   input wire logic insertBipolarViolation,
   input wire logic insertBitError,
   input wire logic qrssGenEnable,
   input wire logic singleRail,
   output logic injectViolation,
   output logic injectBitError
);

   logic txPrev_r, txPrev_nxt;
   logic bpvSample_r, bpvSample_nxt;
   logic berSample_r, berSample_nxt;
   logic injV_r, injV_nxt;
   logic injB_r, injB_nxt;
   logic txRise;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      txRise = txClkSync & ~txPrev_r;
      txPrev_nxt = txClkSync;
      bpvSample_nxt = bpvSample_r;
      berSample_nxt = berSample_r;
      injV_nxt = 1'b0;
      injB_nxt = 1'b0;
      if (txRise) begin
         bpvSample_nxt = insertBipolarViolation;
         berSample_nxt = insertBitError;
         // Violation lands in the QRSS pattern or in single-rail input data
         injV_nxt = insertBipolarViolation & ~bpvSample_r
                    & (qrssGenEnable | singleRail);
         injB_nxt = insertBitError & ~berSample_r & qrssGenEnable;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         txPrev_r <= 1'b0;
         bpvSample_r <= 1'b0;
         berSample_r <= 1'b0;
         injV_r <= 1'b0;
         injB_r <= 1'b0;
      end else begin
         txPrev_r <= txPrev_nxt;
         bpvSample_r <= bpvSample_nxt;
         berSample_r <= berSample_nxt;
         injV_r <= injV_nxt;
         injB_r <= injB_nxt;
      end
   end

   assign injectViolation = injV_r;
   assign injectBitError = injB_r;

endmodule : liu_inject_gen
`default_nettype wire

//--- liu_loop_qual.sv
// Loop-code qualification over a long hold time, manual and automatic modes
`timescale 1ns/1ps
`default_nettype none
`include "liu_cfg.svh"

module liu_loop_qual #(
   parameter logic [`LIU_LOOP_CNT_W-1:0] QUAL_CYCLES = `LIU_LOOP_CNT_W'(`LIU_LOOP_QUAL_CYC)
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [1:0] lcMode,
   input wire logic loopUpSeen,
   input wire logic loopDownSeen,
   output logic loopCodeStatus,
   output logic remoteLoopback
);

   liu_pkg::liuLcState_t state_r, state_nxt;
   logic [`LIU_LOOP_CNT_W-1:0] cnt_r, cnt_nxt;
   logic stat_r, stat_nxt;
   logic run;
   logic qualified;
   logic remote_r, remote_nxt;

   always_comb begin
      state_nxt = state_r;
      stat_nxt = stat_r;
      run = 1'b0;
      case (state_r)
         liu_pkg::LIU_LC_MANUAL: run = loopUpSeen | loopDownSeen;
         liu_pkg::LIU_LC_HUNT: run = loopUpSeen;
         liu_pkg::LIU_LC_HELD: run = loopDownSeen;
         default: run = 1'b0;
      endcase
      // Counter saturates so a code held for hours keeps the bit set
      if (!run) begin
         cnt_nxt = '0;
      end else if (cnt_r == QUAL_CYCLES) begin
         cnt_nxt = cnt_r;
      end else begin
         cnt_nxt = cnt_r + `LIU_LOOP_CNT_W'(1);
      end
      qualified = run & (cnt_r == QUAL_CYCLES);
      case (state_r)
         liu_pkg::LIU_LC_MANUAL: begin
            stat_nxt = qualified;
         end
         liu_pkg::LIU_LC_HUNT: begin
            if (qualified) begin
               state_nxt = liu_pkg::LIU_LC_HELD;
               stat_nxt = 1'b1;
               cnt_nxt = '0;
            end
         end
         liu_pkg::LIU_LC_HELD: begin
            if (qualified) begin
               state_nxt = liu_pkg::LIU_LC_HUNT;
               stat_nxt = 1'b0;
               cnt_nxt = '0;
            end
         end
         default: begin
            stat_nxt = 1'b0;
         end
      endcase
      // A mode change restarts qualification from scratch, except a switch between the two manual codes
      if (lcMode == liu_pkg::LIU_LCM_OFF) begin
         state_nxt = liu_pkg::LIU_LC_OFF;
         stat_nxt = 1'b0;
      end else if (lcMode == liu_pkg::LIU_LCM_AUTO) begin
         if (state_r == liu_pkg::LIU_LC_OFF || state_r == liu_pkg::LIU_LC_MANUAL) begin
            state_nxt = liu_pkg::LIU_LC_HUNT;
            stat_nxt = 1'b0;
            cnt_nxt = '0;
         end
      end else if (state_r != liu_pkg::LIU_LC_MANUAL) begin
         state_nxt = liu_pkg::LIU_LC_MANUAL;
         stat_nxt = 1'b0;
         cnt_nxt = '0;
      end
      // Registered so the loopback output comes straight from a flop
      remote_nxt = (state_nxt == liu_pkg::LIU_LC_HELD);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= liu_pkg::LIU_LC_OFF;
         cnt_r <= '0;
         stat_r <= 1'b0;
         remote_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         stat_r <= stat_nxt;
         remote_r <= remote_nxt;
      end
   end

   assign loopCodeStatus = stat_r;
   assign remoteLoopback = remote_r;

endmodule : liu_loop_qual
`default_nettype wire

//--- liu_chan_regs.sv
// Per-channel control, interrupt enable and live status registers over APB
`timescale 1ns/1ps
`default_nettype none
`include "liu_cfg.svh"

module liu_chan_regs #(
   parameter logic [`LIU_LOOP_CNT_W-1:0] LOOP_QUAL_CYCLES =
      `LIU_LOOP_CNT_W'(`LIU_LOOP_QUAL_CYC)
) (
   input wire logic clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Live status sources and channel transmit clock, asynchronous to clk
   input wire logic driverFailIn,
   input wire logic fifoLimitIn,
   input wire logic codeViolationIn,
   input wire logic allOnesIn,
   input wire logic rxSignalLossIn,
   input wire logic prbsSyncIn,
   input wire logic loopUpSeen,
   input wire logic loopDownSeen,
   input wire logic channelTxClock,
   // Channel controls and events
   output logic [1:0] rxResistorSel,
   output logic rxExtResistorUsed,
   output logic txRatioNarrow,
   output logic injectViolation,
   output logic injectBitError,
   output logic remoteLoopback,
   output logic irq
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   // Index: 0 prbs, 1 loss, 2 all-ones, 3 loop-up, 4 lcv, 5 fifo, 6 driver,
   // 7 loop-down, 8 transmit clock
   logic [`LIU_SYNC_W-1:0] rawIn;
   logic [`LIU_SYNC_W-1:0] syncA_r;
   logic [`LIU_SYNC_W-1:0] syncB_r;

   assign rawIn = {
      channelTxClock,
      loopDownSeen,
      driverFailIn,
      fifoLimitIn,
      codeViolationIn,
      loopUpSeen,
      allOnesIn,
      rxSignalLossIn,
      prbsSyncIn
   };

   // Two flops per lane; only the second one feeds any logic
   genvar gi;
   generate
      for (gi = 0; gi < `LIU_SYNC_W; gi = gi + 1) begin : gSync
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               syncA_r[gi] <= 1'b0;
               syncB_r[gi] <= 1'b0;
            end else begin
               syncA_r[gi] <= rawIn[gi];
               syncB_r[gi] <= syncA_r[gi];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [7:0] resTest_r, resTest_nxt;
   logic [7:0] irqEn_r, irqEn_nxt;
   logic [7:0] cfg_r, cfg_nxt;
   logic [7:0] event_r, event_nxt;
   logic [7:0] prevLive_r, prevLive_nxt;

   // APB answer
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   logic irq_r, irq_nxt;

   // Decoded channel controls
   logic [1:0] resSel_r, resSel_nxt;
   logic extRes_r, extRes_nxt;
   logic ratio_r, ratio_nxt;

   // Combinational views
   logic loopCodeStatus;
   logic [7:0] live;
   logic [7:0] change;
   logic [5:0] idx;
   logic setup;
   logic access;
   logic mapped;
   logic [7:0] rdByte;
   logic evtClr;
   logic [7:0] clrMask;

   // ------------------------------------------------------------
   // Loop-code qualifier and injection
   // ------------------------------------------------------------
   liu_loop_qual #(
      .QUAL_CYCLES(LOOP_QUAL_CYCLES)
   ) uLoopQual (
      .clk(clk),
      .resetn(resetn),
      .lcMode(cfg_r[`LIU_B_LCMODE_HI:`LIU_B_LCMODE_LO]),
      .loopUpSeen(syncB_r[3]),
      .loopDownSeen(syncB_r[7]),
      .loopCodeStatus(loopCodeStatus),
      .remoteLoopback(remoteLoopback)
   );

   // Software must write zero before one; a steady one never re-fires
   liu_inject_gen uInject (
      .clk(clk),
      .resetn(resetn),
      .txClkSync(syncB_r[8]),
      .insertBipolarViolation(resTest_r[`LIU_B_INS_BPV]),
      .insertBitError(resTest_r[`LIU_B_INS_BER]),
      .qrssGenEnable(cfg_r[`LIU_B_QRSS_EN]),
      .singleRail(cfg_r[`LIU_B_SRAIL]),
      .injectViolation(injectViolation),
      .injectBitError(injectBitError)
   );

   // ------------------------------------------------------------
   // Live status and transitions
   // ------------------------------------------------------------
   always_comb begin
      live = `LIU_BYTE_RST;
      live[`LIU_B_DRV] = syncB_r[6];
      live[`LIU_B_FIFO] = syncB_r[5];
      live[`LIU_B_LCV] = syncB_r[4];
      // Loop status is produced on clk and needs no synchroniser
      live[`LIU_B_LOOP] = loopCodeStatus;
      live[`LIU_B_AIS] = syncB_r[2];
      live[`LIU_B_LOS] = syncB_r[1];
      live[`LIU_B_PRBS] = syncB_r[0];
      // Any edge, rising or falling, is an event
      change = (live ^ prevLive_r) & `LIU_SRC_MASK;
      prevLive_nxt = live;
   end

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   always_comb begin
      idx = paddr[7:2];
      setup = psel & ~penable;
      access = psel & penable & pready_r;
      case (idx)
         `LIU_IDX_RESTEST: mapped = 1'b1;
         `LIU_IDX_IRQEN: mapped = 1'b1;
         `LIU_IDX_LIVE: mapped = 1'b1;
         `LIU_IDX_EVENT: mapped = 1'b1;
         `LIU_IDX_CFG: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Read view; unmapped words read as zero
   always_comb begin
      case (idx)
         `LIU_IDX_RESTEST: begin
            rdByte = resTest_r & `LIU_RESTEST_MASK;
         end
         `LIU_IDX_IRQEN: begin
            rdByte = irqEn_r & `LIU_SRC_MASK;
         end
         `LIU_IDX_LIVE: begin
            rdByte = live;
         end
         `LIU_IDX_EVENT: begin
            rdByte = event_r & `LIU_SRC_MASK;
         end
         `LIU_IDX_CFG: begin
            rdByte = cfg_r & `LIU_CFG_MASK;
         end
         default: begin
            rdByte = `LIU_BYTE_RST;
         end
      endcase
   end

   // Answer one cycle after setup: pready rises in the first access cycle
   always_comb begin
      pready_nxt = setup;
      pslverr_nxt = setup & ~mapped;
      prdata_nxt = prdata_r;
      if (setup) begin
         prdata_nxt = (!pwrite) ? {24'h00_0000, rdByte} : `LIU_WORD_RST;
      end else if (access) begin
         prdata_nxt = `LIU_WORD_RST;
      end
   end

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always_comb begin
      resTest_nxt = resTest_r;
      irqEn_nxt = irqEn_r;
      cfg_nxt = cfg_r;
      if (access && pwrite) begin
         case (idx)
            `LIU_IDX_RESTEST: begin
               resTest_nxt = pwdata[7:0] & `LIU_RESTEST_MASK;
            end
            `LIU_IDX_IRQEN: begin
               irqEn_nxt = pwdata[7:0] & `LIU_SRC_MASK;
            end
            `LIU_IDX_CFG: begin
               cfg_nxt = pwdata[7:0] & `LIU_CFG_MASK;
            end
            default: begin
               resTest_nxt = resTest_r;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Sticky events and interrupt request
   // ------------------------------------------------------------
   always_comb begin
      evtClr = access & ~pwrite & (idx == `LIU_IDX_EVENT);
      // Clear only bits the read returned; later events wait for the next read
      clrMask = evtClr ? prdata_r[7:0] : `LIU_BYTE_RST;
      // A new event wins over the clear on the same edge
      event_nxt = ((event_r & ~clrMask)
                   | (change & irqEn_r)) & `LIU_SRC_MASK;
      // Level request held until software reads the event register or clears the matching enable bit
      irq_nxt = |(event_r & irqEn_r);
   end

   // ------------------------------------------------------------
   // Decoded channel controls
   // ------------------------------------------------------------
   always_comb begin
      resSel_nxt = {resTest_r[`LIU_B_RES_HI], resTest_r[`LIU_B_RES_LO]};
      extRes_nxt = (resSel_nxt != `LIU_RES_NONE);
      // Internal termination pins the transformer at 1:2
      ratio_nxt = ~cfg_r[`LIU_B_EXT_TERM] | resTest_r[`LIU_B_RATIO];
   end

   // ------------------------------------------------------------
   // Flip-flops
   // ------------------------------------------------------------
   // Bus answer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata_r <= `LIU_WORD_RST;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // Software-written registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         resTest_r <= `LIU_BYTE_RST;
         irqEn_r <= `LIU_BYTE_RST;
         cfg_r <= `LIU_BYTE_RST;
      end else begin
         resTest_r <= resTest_nxt;
         irqEn_r <= irqEn_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   // Events, transition history and interrupt
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         event_r <= `LIU_BYTE_RST;
         prevLive_r <= `LIU_BYTE_RST;
         irq_r <= 1'b0;
      end else begin
         event_r <= event_nxt;
         prevLive_r <= prevLive_nxt;
         irq_r <= irq_nxt;
      end
   end

   // Decoded controls; reset leaves the transformer at 1:2
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         resSel_r <= `LIU_RES_NONE;
         extRes_r <= 1'b0;
         ratio_r <= 1'b1;
      end else begin
         resSel_r <= resSel_nxt;
         extRes_r <= extRes_nxt;
         ratio_r <= ratio_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq = irq_r;
   assign rxResistorSel = resSel_r;
   assign rxExtResistorUsed = extRes_r;
   assign txRatioNarrow = ratio_r;

endmodule : liu_chan_regs
`default_nettype wire

//--- liu_chan_regs_chk.sv
// Assertion checker for the channel register slice
`timescale 1ns/1ps
`default_nettype none
`include "liu_cfg.svh"

module liu_chan_regs_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [1:0] rxResistorSel,
   input wire logic rxExtResistorUsed,
   input wire logic injectViolation,
   input wire logic injectBitError,
   input wire logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("pready missing in first access cycle");
   ready_single_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   reserved_zero_a: assert property (
      pready && !pwrite && (paddr[7:2] == `LIU_IDX_IRQEN || paddr[7:2] == `LIU_IDX_LIVE)
      |-> prdata[31:7] == 25'h0) else $error("reserved bit read as one");
   res_used_a: assert property (rxExtResistorUsed == (rxResistorSel != 2'h0))
      else $error("resistor flag disagrees with code");
   viol_once_a: assert property (injectViolation |=> !injectViolation)
      else $error("violation pulse too long");
   berr_once_a: assert property (injectBitError |=> !injectBitError)
      else $error("bit error pulse too long");
   // Only a host access may take the interrupt down
   irq_clear_a: assert property ($fell(irq) |-> $past(pready && psel && penable, 2))
      else $error("interrupt dropped without host access");
endmodule : liu_chan_regs_chk

bind liu_chan_regs liu_chan_regs_chk u_chk (.clk(clk), .resetn(resetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .rxResistorSel(rxResistorSel), .rxExtResistorUsed(rxExtResistorUsed),
   .injectViolation(injectViolation), .injectBitError(injectBitError), .irq(irq));
`default_nettype wire

//--- liu_host_model.sv
// Host processor model: APB master reaching the channel registers
`timescale 1ns/1ps
`default_nettype none

module liu_host_model (
   input wire logic clk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [7:0] paddr = 8'h00,
   output logic [31:0] pwdata = 32'h0
);
   // Request held until pready is seen at a rising edge; wait bounded
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic err, output logic ok);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      ok = pready;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   // Zero first; the device sees a rise only if a transmit clock rise samples that zero
   task automatic insertRise(input logic [7:0] a, input logic [7:0] m, output logic ok);
      logic [31:0] rd;
      logic err;
      logic ok0;
      xfer(1'b1, a, 32'h0, rd, err, ok0);
      xfer(1'b1, a, {24'h0, m}, rd, err, ok);
      ok = ok & ok0;
   endtask : insertRise
endmodule : liu_host_model
`default_nettype wire

//--- liu_chan_regs_tb.sv
// Self-checking bench for the channel register slice
`timescale 1ns/1ps
`default_nettype none
`include "liu_cfg.svh"

module liu_chan_regs_tb;
   localparam int QUAL = 20;
   localparam logic [7:0] A_CTL = {`LIU_IDX_RESTEST, 2'b00};
   localparam logic [7:0] A_EN = {`LIU_IDX_IRQEN, 2'b00};
   localparam logic [7:0] A_LIVE = {`LIU_IDX_LIVE, 2'b00};
   localparam logic [7:0] A_EVT = {`LIU_IDX_EVENT, 2'b00};
   localparam logic [7:0] A_CFG = {`LIU_IDX_CFG, 2'b00};
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic txClk = 1'b0;
   logic [6:0] liveIn = 7'h00;
   logic loopUp = 1'b0;
   logic loopDown = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, err, ok;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] rxResistorSel;
   logic rxExtResistorUsed, txRatioNarrow, injectViolation, injectBitError, remoteLoopback, irq;
   int error_cnt = 0;
   int samples_checked = 0;
   int nViol = 0;
   int nBer = 0;
   int v0, b0;
   int srcBit[6] = '{6, 5, 4, 2, 1, 0};
   logic [7:0] injCfg[5] = '{8'h08, 8'h08, 8'h10, 8'h10, 8'h00};
   logic [7:0] injBit[5] = '{8'h04, 8'h02, 8'h04, 8'h02, 8'h04};
   int expV[5] = '{1, 0, 1, 0, 0};
   int expB[5] = '{0, 1, 0, 0, 0};

   always #50 clk = ~clk;
   // Transmit clock far below the 5 MHz limit of its synchroniser
   always #800 txClk = ~txClk;
   always @(posedge clk) begin
      if (injectViolation === 1'b1) nViol++;
      if (injectBitError === 1'b1) nBer++;
   end

   liu_host_model host (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   liu_chan_regs #(.LOOP_QUAL_CYCLES(`LIU_LOOP_CNT_W'(QUAL))) dut (.clk(clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .driverFailIn(liveIn[6]),
      .fifoLimitIn(liveIn[5]), .codeViolationIn(liveIn[4]), .allOnesIn(liveIn[2]),
      .rxSignalLossIn(liveIn[1]), .prbsSyncIn(liveIn[0]), .loopUpSeen(loopUp),
      .loopDownSeen(loopDown), .channelTxClock(txClk), .rxResistorSel(rxResistorSel),
      .rxExtResistorUsed(rxExtResistorUsed), .txRatioNarrow(txRatioNarrow),
      .injectViolation(injectViolation), .injectBitError(injectBitError),
      .remoteLoopback(remoteLoopback), .irq(irq));

   task automatic final_report();
      $display("compared %0d, mismatched %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      host.xfer(wr, a, {24'h0, d}, rd, err, ok);
      check("pready", ok, 1);
      if (ok !== 1'b1) final_report();
   endtask : bus

   task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00);
      check(what, rd, exp);
   endtask : rdChk

   // Let registered outputs settle away from the edge
   task automatic settle();
      repeat (2) @(negedge clk);
   endtask : settle

   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      check("ratio reset", txRatioNarrow, 1);
      rdChk("ctl reset", A_CTL, 0);
      rdChk("enable reset", A_EN, 0);
      rdChk("live reset", A_LIVE, 0);
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, A_CTL, 8'(c << `LIU_B_RES_LO));
         settle();
         check("resistor code", rxResistorSel, c);
         check("ext resistor", rxExtResistorUsed, c != 0);
         rdChk("ctl readback", A_CTL, c << `LIU_B_RES_LO);
      end
      bus(1'b1, A_CFG, 8'h04);
      bus(1'b1, A_CTL, 8'h01);
      settle();
      check("ratio ext one", txRatioNarrow, 1);
      bus(1'b1, A_CTL, 8'h00);
      settle();
      check("ratio ext zero", txRatioNarrow, 0);
      bus(1'b1, A_CFG, 8'h00);
      settle();
      check("ratio internal", txRatioNarrow, 1);
      $display("test control done");
      bus(1'b1, A_EN, 8'hFF);
      rdChk("enable reserved", A_EN, 32'h7F);
      bus(1'b1, A_LIVE, 8'hFF);
      rdChk("live read only", A_LIVE, 0);
      bus(1'b0, 8'h40, 8'h00);
      check("unmapped error", err, 1);
      check("unmapped data", rd, 0);
      foreach (srcBit[i]) begin
         liveIn[srcBit[i]] <= 1'b1;
         repeat (6) @(posedge clk);
         check("irq raised", irq, 1);
         rdChk("live bit", A_LIVE, 1 << srcBit[i]);
         rdChk("event rise", A_EVT, 1 << srcBit[i]);
         repeat (3) @(posedge clk);
         check("irq cleared", irq, 0);
         liveIn[srcBit[i]] <= 1'b0;
         repeat (6) @(posedge clk);
         rdChk("event fall", A_EVT, 1 << srcBit[i]);
      end
      bus(1'b1, A_EN, 8'h00);
      liveIn[`LIU_B_DRV] <= 1'b1;
      repeat (6) @(posedge clk);
      check("irq masked", irq, 0);
      rdChk("masked event", A_EVT, 0);
      rdChk("masked live", A_LIVE, 32'h40);
      liveIn[`LIU_B_DRV] <= 1'b0;
      $display("test status done");
      bus(1'b1, A_EN, 8'h08);
      bus(1'b1, A_CFG, 8'h01);
      for (int k = 0; k < 2; k++) begin
         loopUp <= (k == 0);
         loopDown <= (k == 1);
         repeat (QUAL / 2) @(posedge clk);
         rdChk("loop early", A_LIVE, 0);
         repeat (QUAL) @(posedge clk);
         rdChk("loop held", A_LIVE, 32'h08);
         loopUp <= 1'b0;
         loopDown <= 1'b0;
         repeat (6) @(posedge clk);
         rdChk("loop gone", A_LIVE, 0);
         rdChk("loop event", A_EVT, 32'h08);
      end
      bus(1'b1, A_CFG, 8'h03);
      loopUp <= 1'b1;
      repeat (QUAL + 8) @(posedge clk);
      check("loopback on", remoteLoopback, 1);
      loopUp <= 1'b0;
      loopDown <= 1'b1;
      repeat (QUAL / 2) @(posedge clk);
      rdChk("loop kept", A_LIVE, 32'h08);
      check("loopback kept", remoteLoopback, 1);
      repeat (QUAL) @(posedge clk);
      check("loopback off", remoteLoopback, 0);
      loopDown <= 1'b0;
      $display("test loop code done");
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, A_CFG, injCfg[i]);
         v0 = nViol;
         b0 = nBer;
         host.insertRise(A_CTL, injBit[i], ok);
         repeat (48) @(posedge clk);
         check("violations", nViol - v0, expV[i]);
         check("bit errors", nBer - b0, expB[i]);
      end
      bus(1'b1, A_CFG, 8'h08);
      bus(1'b1, A_CTL, 8'h04);
      v0 = nViol;
      repeat (48) @(posedge clk);
      check("no rise", nViol - v0, 0);
      $display("test inject done");
      final_report();
   end
endmodule : liu_chan_regs_tb
`default_nettype wire
